// *** hdl/cscr_defs.vh ***
// constants for the core status and configuration register bank
`ifndef CSCR_DEFS_VH
`define CSCR_DEFS_VH
// register addresses on the plain register port
`define CSCR_ADDR_W 2
`define CSCR_ADDR_STATUS 2'h0
`define CSCR_ADDR_CONFIG 2'h1
// reset values
`define CSCR_CFG_RESET 16'h0020
`define CSCR_SR_RESET 16'h0000
// status bit positions
`define CSCR_SR_OA 15
`define CSCR_SR_OB 14
`define CSCR_SR_SA 13
`define CSCR_SR_SB 12
`define CSCR_SR_OAB 11
`define CSCR_SR_SAB 10
`define CSCR_SR_DA 9
`define CSCR_SR_DC 8
`define CSCR_SR_IPL_HI 7
`define CSCR_SR_IPL_LO 5
`define CSCR_SR_RA 4
`define CSCR_SR_N 3
`define CSCR_SR_OV 2
`define CSCR_SR_Z 1
`define CSCR_SR_C 0
// configuration bit positions
`define CSCR_CF_US 12
`define CSCR_CF_EDT 11
`define CSCR_CF_DL_HI 10
`define CSCR_CF_DL_LO 8
`define CSCR_CF_DL1 9
`define CSCR_CF_DL0 8
`define CSCR_CF_ACC_A_CLAMP_EN 7
`define CSCR_CF_ACC_B_CLAMP_EN 6
`define CSCR_CF_STORE_CLAMP_EN 5
`define CSCR_CF_SUPER_CLAMP_SEL 4
`define CSCR_CF_TRAP_LEVEL_FLAG 3
`define CSCR_CF_PSV 2
`define CSCR_CF_RND 1
`define CSCR_CF_IF 0
// loop nest level limits, priority level and mcu flag widths
`define CSCR_DL_W 3
`define CSCR_DL_ZERO 3'h0
`define CSCR_DL_ONE 3'h1
`define CSCR_DL_MAX 3'h7
`define CSCR_IPL_W 3
`define CSCR_MCU_W 5
`endif

// *** hdl/cscr_shadow.v ***
// one-deep shadow holding register
`timescale 1ns/100ps
`default_nettype none
module cscr_shadow #(
    parameter W = 16
) (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire i_save,
    input wire [W-1:0] i_live,
    output wire [W-1:0] o_saved
);
    reg [W-1:0] held_q;
    // capture the live value when asked, one entry only
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            held_q <= {W{1'b0}};
        end else if (i_save) begin
            held_q <= i_live;
        end
    end
    assign o_saved = held_q;
endmodule // cscr_shadow
`default_nettype wire

// *** hdl/cscr_regs.v ***
// core status and configuration register bank with loop and flag shadows
// What this block does
// - configuration register resets to 0020 hex
// - loop setup copies loop count, first and last address into shadows
// - push-shadow saves mcu flags and work regs 0-3; pop-shadow restores them
// - shadows are one deep and have no software access
// - nest level reads 0 idle, 1 single loop, depth when nested
// - upper two nest level bits read only; hardware tracks up to seven levels
// - writing 1 to early exit ends loop after iteration; reads zero
// - bit 12 selects unsigned multiply; bits 15-13 read zero
// - bit 0 selects integer multiply, else fractional
// - bits 7 and 6 enable saturation of accumulators a and b
// - bit 5 enables saturation of dsp writes to data space
// - bit 4 selects 9.31 super saturation, else 1.31 normal
// - bit 1 selects biased rounding, else convergent
// - bit 2 makes program space visible in data space
// - bit 3 shows trap active; software clears only; top priority bit
// - status bits 7-5 hold low priority bits; effective adds eight on trap
// - sticky saturation flags stay set; software may only clear them
// - bit 10 is or of sticky flags; clearing it clears both
// - bits 15,14 read-only overflow flags; bit 11 their or
// - bit 8 half carry from datapath, software writable
// - bits 3-0 negative, overflow, zero, carry; software writable
// - loop active set at first loop instruction, cleared after final pass
// - carry acts as inverted borrow on subtract
// - trap bit set only by hardware trap, cleared after service
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "cscr_defs.vh"
module cscr_regs (
    input wire i_ref_clk,
    input wire i_rstn,
    // register port
    input wire [`CSCR_ADDR_W-1:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [15:0] o_rdata,
    // datapath flag updates
    input wire i_mcu_upd,
    input wire i_sub_op,
    input wire i_res_neg,
    input wire i_res_ovf,
    input wire i_res_zero,
    input wire i_carry_out,
    input wire i_half_carry_out,
    input wire i_dsp_upd,
    input wire i_acc_a_ovf,
    input wire i_acc_b_ovf,
    input wire i_acc_a_sat_evt,
    input wire i_acc_b_sat_evt,
    input wire i_repeat_active,
    // exception logic
    input wire i_trap_set,
    input wire i_trap_done,
    input wire i_ipl_load,
    input wire [`CSCR_IPL_W-1:0] i_ipl_value,
    // loop sequencing
    input wire i_loop_setup,
    input wire [15:0] i_loop_count,
    input wire [23:0] i_loop_first,
    input wire [23:0] i_loop_last,
    input wire i_loop_first_exec,
    input wire i_loop_done,
    input wire [15:0] i_loop_count_live,
    // shadow push and pop
    input wire i_push_shadow,
    input wire i_pop_shadow,
    input wire [63:0] i_work_regs_low,
    output reg [63:0] o_work_regs_low,
    output reg o_work_restore,
    // loop register restore
    output reg o_loop_restore,
    output reg [15:0] o_loop_count_reg,
    output reg [23:0] o_loop_first_addr,
    output reg [23:0] o_loop_last_addr,
    output reg o_loop_early_exit,
    // live register views and mode selects
    output wire [15:0] o_core_status_reg,
    output wire [15:0] o_core_config_reg,
    output wire [3:0] o_cpu_priority_level,
    output wire o_multiplier_unsigned_sel,
    output wire o_multiplier_integer_sel,
    output wire o_acc_a_clamp_en,
    output wire o_acc_b_clamp_en,
    output wire o_store_clamp_en,
    output wire o_super_clamp_sel,
    output wire o_round_mode_sel,
    output wire o_prog_window_en
);
    // ******************************************************************
    // state
    // ******************************************************************
    reg acc_a_ovf_q;
    reg acc_b_ovf_q;
    reg acc_a_clamp_q;
    reg acc_b_clamp_q;
    reg loop_active_q;
    reg repeat_active_q;
    reg half_carry_q;
    reg neg_q;
    reg ovf_q;
    reg zero_q;
    reg carry_q;
    reg [`CSCR_IPL_W-1:0] ipl_q;
    reg trap_level_q;
    reg [`CSCR_DL_W-1:0] nest_q;
    reg unsigned_q;
    reg integer_q;
    reg acc_a_clamp_en_q;
    reg acc_b_clamp_en_q;
    reg store_clamp_en_q;
    reg super_clamp_sel_q;
    reg psv_q;
    reg rnd_q;
    // i_loop_count_live is a spare input and is not used here
    // write decodes for the two mapped addresses
    wire wr_sr = i_wr && (i_addr == `CSCR_ADDR_STATUS);
    wire wr_cf = i_wr && (i_addr == `CSCR_ADDR_CONFIG);
    // every configuration bit resets from one constant
    wire [15:0] cfg_rst = `CSCR_CFG_RESET;
    // shadow outputs, never on the read path
    wire [`CSCR_MCU_W-1:0] mcu_saved;
    wire [63:0] work_saved;
    wire [63:0] loop_saved;
    // ******************************************************************
    // one-deep shadows, no software path
    // ******************************************************************
    // loop registers shadowed on loop setup
    cscr_shadow #(.W(64)) u_loop_sh (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_save(i_loop_setup),
        .i_live({i_loop_count, i_loop_first, i_loop_last}),
        .o_saved(loop_saved)
    );
    // mcu flags shadowed on push
    cscr_shadow #(.W(`CSCR_MCU_W)) u_mcu_sh (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_save(i_push_shadow),
        .i_live({half_carry_q, neg_q, ovf_q, zero_q, carry_q}),
        .o_saved(mcu_saved)
    );
    // work regs 0-3 shadowed on push
    cscr_shadow #(.W(64)) u_work_sh (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_save(i_push_shadow),
        .i_live(i_work_regs_low),
        .o_saved(work_saved)
    );
    // ******************************************************************
    // status register
    // ******************************************************************
    // dsp flags: overflow live, saturation sticky with set over clear
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            acc_a_ovf_q <= 1'b0;
            acc_b_ovf_q <= 1'b0;
            acc_a_clamp_q <= 1'b0;
            acc_b_clamp_q <= 1'b0;
            repeat_active_q <= 1'b0;
        end else begin
            if (i_dsp_upd) begin
                acc_a_ovf_q <= i_acc_a_ovf;
                acc_b_ovf_q <= i_acc_b_ovf;
            end
            repeat_active_q <= i_repeat_active;
            if (i_acc_a_sat_evt) begin
                acc_a_clamp_q <= 1'b1;
            end else if (wr_sr && (!i_wdata[`CSCR_SR_SA] || !i_wdata[`CSCR_SR_SAB])) begin
                acc_a_clamp_q <= 1'b0;
            end
            if (i_acc_b_sat_evt) begin
                acc_b_clamp_q <= 1'b1;
            end else if (wr_sr && (!i_wdata[`CSCR_SR_SB] || !i_wdata[`CSCR_SR_SAB])) begin
                acc_b_clamp_q <= 1'b0;
            end
        end
    end
    // mcu flags: pop, then datapath, then software write
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            half_carry_q <= 1'b0;
            neg_q <= 1'b0;
            ovf_q <= 1'b0;
            zero_q <= 1'b0;
            carry_q <= 1'b0;
        end else if (i_pop_shadow) begin
            {half_carry_q, neg_q, ovf_q, zero_q, carry_q} <= mcu_saved;
        end else if (i_mcu_upd) begin
            half_carry_q <= i_half_carry_out;
            neg_q <= i_res_neg;
            ovf_q <= i_res_ovf;
            zero_q <= i_res_zero;
            // subtract hands over a borrow, stored inverted
            carry_q <= i_sub_op ? ~i_carry_out : i_carry_out;
        end else if (wr_sr) begin
            half_carry_q <= i_wdata[`CSCR_SR_DC];
            neg_q <= i_wdata[`CSCR_SR_N];
            ovf_q <= i_wdata[`CSCR_SR_OV];
            zero_q <= i_wdata[`CSCR_SR_Z];
            carry_q <= i_wdata[`CSCR_SR_C];
        end
    end
    // priority level: exception entry wins over software
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            ipl_q <= {`CSCR_IPL_W{1'b0}};
        end else if (i_ipl_load) begin
            ipl_q <= i_ipl_value;
        end else if (wr_sr) begin
            ipl_q <= i_wdata[`CSCR_SR_IPL_HI:`CSCR_SR_IPL_LO];
        end
    end
    // ******************************************************************
    // loop tracking
    // ******************************************************************
    // active flag and nest level driven by loop events
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            loop_active_q <= 1'b0;
            nest_q <= cfg_rst[`CSCR_CF_DL_HI:`CSCR_CF_DL_LO];
            o_loop_restore <= 1'b0;
            o_loop_count_reg <= 16'h0000;
            o_loop_first_addr <= 24'h000000;
            o_loop_last_addr <= 24'h000000;
        end else begin
            o_loop_restore <= 1'b0;
            // depth stops at seven; only bit 0 is open to software
            if (i_loop_setup && i_loop_done) begin
                nest_q <= nest_q; // one ends as another begins
            end else if (i_loop_setup) begin
                if (nest_q != `CSCR_DL_MAX) begin
                    nest_q <= nest_q + `CSCR_DL_ONE;
                end
            end else if (i_loop_done && (nest_q != `CSCR_DL_ZERO)) begin
                nest_q <= nest_q - `CSCR_DL_ONE;
                if (nest_q != `CSCR_DL_ONE) begin
                    o_loop_restore <= 1'b1;
                    {o_loop_count_reg, o_loop_first_addr, o_loop_last_addr} <= loop_saved;
                end
            end else if (wr_cf) begin
                nest_q[0] <= i_wdata[`CSCR_CF_DL0];
            end
            if (i_loop_first_exec) begin
                loop_active_q <= 1'b1;
            end else if (i_loop_done && (nest_q == `CSCR_DL_ONE) && !i_loop_setup) begin
                loop_active_q <= 1'b0;
            end
        end
    end
    // early exit is a write-one pulse, never stored
    // a request while no loop runs is dropped
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_loop_early_exit <= 1'b0;
        end else begin
            o_loop_early_exit <= wr_cf && i_wdata[`CSCR_CF_EDT] && loop_active_q;
        end
    end
    // ******************************************************************
    // configuration register
    // ******************************************************************
    // mode bits and trap level
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            unsigned_q <= cfg_rst[`CSCR_CF_US];
            acc_a_clamp_en_q <= cfg_rst[`CSCR_CF_ACC_A_CLAMP_EN];
            acc_b_clamp_en_q <= cfg_rst[`CSCR_CF_ACC_B_CLAMP_EN];
            store_clamp_en_q <= cfg_rst[`CSCR_CF_STORE_CLAMP_EN];
            super_clamp_sel_q <= cfg_rst[`CSCR_CF_SUPER_CLAMP_SEL];
            psv_q <= cfg_rst[`CSCR_CF_PSV];
            rnd_q <= cfg_rst[`CSCR_CF_RND];
            integer_q <= cfg_rst[`CSCR_CF_IF];
            trap_level_q <= cfg_rst[`CSCR_CF_TRAP_LEVEL_FLAG];
        end else begin
            if (wr_cf) begin
                unsigned_q <= i_wdata[`CSCR_CF_US];
                acc_a_clamp_en_q <= i_wdata[`CSCR_CF_ACC_A_CLAMP_EN];
                acc_b_clamp_en_q <= i_wdata[`CSCR_CF_ACC_B_CLAMP_EN];
                store_clamp_en_q <= i_wdata[`CSCR_CF_STORE_CLAMP_EN];
                super_clamp_sel_q <= i_wdata[`CSCR_CF_SUPER_CLAMP_SEL];
                psv_q <= i_wdata[`CSCR_CF_PSV];
                rnd_q <= i_wdata[`CSCR_CF_RND];
                integer_q <= i_wdata[`CSCR_CF_IF];
            end
            // trap entry beats a software clear in the same cycle
            if (i_trap_set) begin
                trap_level_q <= 1'b1;
            end else if (i_trap_done || (wr_cf && !i_wdata[`CSCR_CF_TRAP_LEVEL_FLAG])) begin
                trap_level_q <= 1'b0;
            end
        end
    end
    // ******************************************************************
    // shadow restore of work regs and read path
    // ******************************************************************
    // work regs 0-3 handed back on pop
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_work_regs_low <= 64'h0000000000000000;
            o_work_restore <= 1'b0;
        end else begin
            o_work_restore <= i_pop_shadow;
            if (i_pop_shadow) begin
                o_work_regs_low <= work_saved;
            end
        end
    end
    // assembled register views
    assign o_core_status_reg = {acc_a_ovf_q, acc_b_ovf_q, acc_a_clamp_q, acc_b_clamp_q,
        acc_a_ovf_q | acc_b_ovf_q, acc_a_clamp_q | acc_b_clamp_q,
        loop_active_q, half_carry_q, ipl_q, repeat_active_q,
        neg_q, ovf_q, zero_q, carry_q};
    // configuration view: unused bits and early exit read zero
    assign o_core_config_reg = {3'h0, unsigned_q, 1'b0, nest_q,
        acc_a_clamp_en_q, acc_b_clamp_en_q, store_clamp_en_q, super_clamp_sel_q, trap_level_q, psv_q, rnd_q, integer_q};
    assign o_cpu_priority_level = {trap_level_q, ipl_q};
    // mode selects straight from their flops
    assign o_multiplier_unsigned_sel = unsigned_q;
    assign o_multiplier_integer_sel = integer_q;
    assign o_acc_a_clamp_en = acc_a_clamp_en_q;
    assign o_acc_b_clamp_en = acc_b_clamp_en_q;
    assign o_store_clamp_en = store_clamp_en_q;
    assign o_super_clamp_sel = super_clamp_sel_q;
    assign o_round_mode_sel = rnd_q;
    assign o_prog_window_en = psv_q;
    // read data one cycle after the read strobe, zero otherwise
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_rdata <= 16'h0000;
        end else if (i_rd && (i_addr == `CSCR_ADDR_STATUS)) begin
            o_rdata <= o_core_status_reg;
        end else if (i_rd && (i_addr == `CSCR_ADDR_CONFIG)) begin
            o_rdata <= o_core_config_reg;
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule // cscr_regs
`default_nettype wire

// *** sim/cscr_regs_props.sv ***
// assertions on the ports of the core status and configuration register bank
`timescale 1ns/100ps
`default_nettype none
module cscr_regs_props (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic [1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic i_acc_a_sat_evt,
    input wire logic i_trap_set,
    input wire logic i_loop_setup,
    input wire logic i_loop_done,
    input wire logic i_pop_shadow,
    input wire logic i_repeat_active,
    input wire logic o_work_restore,
    input wire logic o_loop_restore,
    input wire logic o_loop_early_exit,
    input wire logic [15:0] o_core_status_reg,
    input wire logic [15:0] o_core_config_reg,
    input wire logic [3:0] o_cpu_priority_level
);
    // ******************************
    // helper views
    // ******************************
    wire [15:0] sr = o_core_status_reg;
    wire [15:0] cf = o_core_config_reg;
    wire [2:0] nest = o_core_config_reg[10:8];
    wire exit_req = i_wr && (i_addr == 2'h1) && i_wdata[11] && sr[9];
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    // ******************************
    // properties
    // ******************************
    AST_CFG_RESET: assert property (disable iff (1'b0)
        !i_rstn |=> cf == 16'h0020) else $error("config reset value wrong");
    AST_CFG_FIXED: assert property (
        cf[15:13] == 3'h0 && !cf[11]) else $error("config fixed bits not zero");
    AST_RD_STATUS: assert property (
        i_rd && i_addr == 2'h0 |=> o_rdata == $past(sr)) else $error("status read wrong");
    AST_RD_UNMAPPED: assert property (
        i_rd && i_addr[1] |=> o_rdata == 16'h0000) else $error("unmapped read not zero");
    AST_OR_FLAGS: assert property (
        sr[10] == (sr[13] | sr[12]) && sr[11] == (sr[15] | sr[14])) else $error("or flags wrong");
    AST_STICKY_HOLD: assert property (
        sr[13] && !(i_wr && i_addr == 2'h0) |=> sr[13]) else $error("sticky flag lost");
    AST_STICKY_NOSET: assert property (
        !sr[13] && !i_acc_a_sat_evt |=> !sr[13]) else $error("sticky flag set by software");
    AST_SAT_SET: assert property (
        i_acc_a_sat_evt |=> sr[13]) else $error("saturation event not recorded");
    AST_TRAP_NOSET: assert property (
        !cf[3] && !i_trap_set |=> !cf[3]) else $error("trap bit set without trap");
    AST_PRIO: assert property (
        o_cpu_priority_level == {cf[3], sr[7:5]}) else $error("priority level wrong");
    AST_EXIT: assert property (
        1'b1 |=> o_loop_early_exit == $past(exit_req)) else $error("early exit pulse wrong");
    AST_RA: assert property (
        1'b1 |=> sr[4] == $past(i_repeat_active)) else $error("repeat flag wrong");
    AST_RESTORE: assert property (
        o_loop_restore |-> $past(i_loop_done)) else $error("loop restore without loop end");
    AST_POP: assert property (
        i_pop_shadow |=> o_work_restore) else $error("pop without work restore");
    AST_NEST_UP: assert property (
        i_loop_setup && !i_loop_done && nest != 3'h7 |=> nest == $past(nest) + 3'h1)
        else $error("nest level not raised");
    // main scenarios reached
    COV_RESTORE: cover property (o_loop_restore);
    COV_EXIT: cover property (o_loop_early_exit);
    COV_TRAP: cover property (i_trap_set ##1 o_cpu_priority_level[3]);
endmodule // cscr_regs_props
bind cscr_regs cscr_regs_props u_props (.*);
`default_nettype wire

// *** sim/cscr_dp_model.sv ***
// behavioural alu model that feeds flag results to the register bank
`timescale 1ns/100ps
`default_nettype none
module cscr_dp_model (
    input wire logic i_go,
    input wire logic i_sub,
    input wire logic [15:0] i_a,
    input wire logic [15:0] i_b,
    output logic o_upd,
    output logic o_neg,
    output logic o_ovf,
    output logic o_zero,
    output logic o_carry,
    output logic o_half
);
    // ******************************
    // add or subtract, carry out as borrow on subtract
    // ******************************
    logic [16:0] s;
    logic [4:0] h;
    logic [4:0] f;
    logic ov;
    // flags are inverted outside an update so stale values are never seen
    always_comb begin
        s = {1'b0, i_a} + {1'b0, i_sub ? ~i_b : i_b} + {16'h0000, i_sub};
        h = {1'b0, i_a[3:0]} + {1'b0, i_sub ? ~i_b[3:0] : i_b[3:0]} + {4'h0, i_sub};
        ov = (i_a[15] == (i_sub ? ~i_b[15] : i_b[15])) && (s[15] != i_a[15]);
        f = {s[15], ov, s[15:0] == 16'h0000, i_sub ? ~s[16] : s[16], h[4]};
        o_upd = i_go;
        {o_neg, o_ovf, o_zero, o_carry, o_half} = i_go ? f : ~f;
    end
endmodule // cscr_dp_model
`default_nettype wire

// *** sim/cscr_regs_test.sv ***
// self-checking bench for the core status and configuration register bank
`timescale 1ns/100ps
`default_nettype none
module cscr_regs_test;
    // ******************************
    // signals
    // ******************************
    logic i_ref_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_sub_op = 1'b0;
    logic i_acc_a_ovf = 1'b0, i_acc_b_ovf = 1'b0, i_repeat_active = 1'b0;
    logic [1:0] i_addr = 2'h0;
    logic [2:0] i_ipl_value = 3'h0;
    logic [11:0] pv = 12'h000;
    logic [15:0] i_wdata = 16'h0000, i_loop_count = 16'h0000, i_loop_count_live = 16'h0000;
    logic [15:0] op_a = 16'h0000, op_b = 16'h0000, d;
    logic [23:0] i_loop_first = 24'h000000, i_loop_last = 24'h000000;
    logic [63:0] i_work_regs_low = 64'h0, wv;
    wire go, i_dsp_upd, i_acc_a_sat_evt, i_acc_b_sat_evt, i_trap_set, i_trap_done, i_ipl_load;
    wire i_loop_setup, i_loop_first_exec, i_loop_done, i_push_shadow, i_pop_shadow;
    wire i_mcu_upd, i_res_neg, i_res_ovf, i_res_zero, i_carry_out, i_half_carry_out;
    wire o_work_restore, o_loop_restore, o_loop_early_exit, o_multiplier_unsigned_sel;
    wire o_multiplier_integer_sel, o_acc_a_clamp_en, o_acc_b_clamp_en, o_store_clamp_en;
    wire o_super_clamp_sel, o_round_mode_sel, o_prog_window_en;
    wire [15:0] o_rdata, o_loop_count_reg, o_core_status_reg, o_core_config_reg;
    wire [23:0] o_loop_first_addr, o_loop_last_addr;
    wire [63:0] o_work_regs_low;
    wire [3:0] o_cpu_priority_level;
    wire [15:0] sr = o_core_status_reg;
    wire [15:0] cf = o_core_config_reg;
    wire [7:0] modes = {o_multiplier_unsigned_sel, o_multiplier_integer_sel, o_acc_a_clamp_en,
        o_acc_b_clamp_en, o_store_clamp_en, o_super_clamp_sel, o_round_mode_sel, o_prog_window_en};
    int errors = 0, comparisons = 0;
    // event pulses from one vector
    assign {i_pop_shadow, i_push_shadow, i_loop_done, i_loop_first_exec, i_loop_setup, i_ipl_load,
        i_trap_done, i_trap_set, i_acc_b_sat_evt, i_acc_a_sat_evt, i_dsp_upd, go} = pv;
    cscr_regs dut (.*);
    cscr_dp_model model (.i_go(go), .i_sub(i_sub_op), .i_a(op_a), .i_b(op_b), .o_upd(i_mcu_upd),
        .o_neg(i_res_neg), .o_ovf(i_res_ovf), .o_zero(i_res_zero), .o_carry(i_carry_out),
        .o_half(i_half_carry_out));
    // ******************************
    // tasks and expectations
    // ******************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] v);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [1:0] a, input logic [15:0] e);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    task automatic ev(input logic [11:0] m);
        @(posedge i_ref_clk);
        pv <= m;
        @(posedge i_ref_clk);
        pv <= 12'h000;
        #1;
    endtask
    function automatic logic [15:0] mcu_exp(input logic [15:0] a, b, input logic s);
        logic [16:0] r;
        logic dc, c, ov;
        r = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        c = s ? (a >= b) : r[16];
        dc = s ? (a[3:0] >= b[3:0]) : ({1'b0, a[3:0]} + {1'b0, b[3:0]} > 5'h0F);
        ov = ((a[15] ^ b[15]) == s) && (r[15] != a[15]);
        return {7'h00, dc, 4'h0, r[15], ov, r[15:0] == 16'h0000, c};
    endfunction
    task automatic tally_and_finish;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ******************************
    // clock, watchdog and tests
    // ******************************
    initial forever #5 i_ref_clk = ~i_ref_clk;
    initial begin
        #100000;
        errors++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(94987));
        repeat (6) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        rd(2'h1, 16'h0020);
        rd(2'h0, 16'h0000);
        chk(modes, 8'h08);
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 16'hFFFF : 16'($urandom);
            wr(2'h1, d);
            chk(cf, d & 16'h11F7);
            chk(modes, {d[12], d[0], d[7], d[6], d[5], d[4], d[1], d[2]});
            rd(2'h1, d & 16'h11F7);
            d = (i == 0) ? 16'hFFFF : 16'($urandom);
            wr(2'h0, d);
            chk(sr, d & 16'h01EF);
            chk(o_cpu_priority_level, {1'b0, d[7:5]});
        end
        wr(2'h1, 16'h0020);
        wr(2'h0, 16'h0000);
        wr(2'h3, 16'hFFFF);
        rd(2'h2, 16'h0000);
        chk({sr, cf}, 32'h00000020);
        $display("test register access done");
        for (int i = 0; i < 12; i++) begin
            {op_a, op_b, i_sub_op} <= (i == 0) ? {16'h7FFF, 16'h0001, 1'b0} :
                (i == 1) ? {16'h1234, 16'h1234, 1'b1} : 33'({$urandom, $urandom});
            ev(12'h001);
            chk(sr & 16'h010F, mcu_exp(op_a, op_b, i_sub_op));
        end
        $display("test alu flags done");
        ev(12'h004);
        chk(sr & 16'h3C00, 16'h2400);
        wr(2'h0, 16'h2400);
        chk(sr & 16'h3C00, 16'h2400);
        ev(12'h008);
        chk(sr & 16'h3C00, 16'h3400);
        wr(2'h0, 16'h3000);
        chk(sr & 16'h3C00, 16'h0000);
        fork
            wr(2'h0, 16'h0000);
            ev(12'h004);
        join
        chk(sr & 16'h3C00, 16'h2400);
        {i_acc_a_ovf, i_acc_b_ovf} <= 2'b10;
        ev(12'h002);
        wr(2'h0, 16'h0000);
        chk(sr & 16'hC800, 16'h8800);
        {i_acc_a_ovf, i_acc_b_ovf} <= 2'b01;
        ev(12'h002);
        chk(sr & 16'hC800, 16'h4800);
        i_repeat_active <= 1'b1;
        ev(12'h000);
        chk(sr & 16'h0010, 16'h0010);
        $display("test dsp flags done");
        i_ipl_value <= 3'h5;
        ev(12'h040);
        wr(2'h1, 16'h0028);
        chk({cf, o_cpu_priority_level}, 20'h00205);
        ev(12'h010);
        wr(2'h1, 16'h0028);
        chk(o_cpu_priority_level, 4'hD);
        wr(2'h1, 16'h0020);
        chk(o_cpu_priority_level, 4'h5);
        ev(12'h010);
        ev(12'h020);
        chk(o_cpu_priority_level, 4'h5);
        $display("test priority done");
        {i_loop_count, i_loop_first, i_loop_last} <= 64'({$urandom, $urandom});
        ev(12'h080);
        chk(cf & 16'h0700, 16'h0100);
        ev(12'h100);
        chk(sr & 16'h0200, 16'h0200);
        wr(2'h1, 16'h0F20);
        chk({o_loop_early_exit, cf}, 17'h10120);
        wv = {$urandom, $urandom};
        {i_loop_count, i_loop_first, i_loop_last} <= wv;
        ev(12'h080);
        chk(cf & 16'h0700, 16'h0200);
        {i_loop_count, i_loop_first, i_loop_last} <= ~wv;
        ev(12'h200);
        chk({o_loop_count_reg, o_loop_first_addr, o_loop_last_addr}, wv);
        chk({o_loop_restore, cf & 16'h0700}, 17'h10100);
        ev(12'h200);
        chk({o_loop_restore, cf & 16'h0700, sr & 16'h0200}, 33'h0);
        $display("test loops done");
        wr(2'h0, 16'h0105);
        wv = {$urandom, $urandom};
        i_work_regs_low <= wv;
        ev(12'h400);
        wr(2'h0, 16'h000A);
        i_work_regs_low <= ~wv;
        ev(12'h800);
        chk({o_work_restore, sr & 16'h010F}, 17'h10105);
        chk(o_work_regs_low, wv);
        $display("test shadows done");
        tally_and_finish;
    end
endmodule // cscr_regs_test
`default_nettype wire
